// *** pkg/wdo_pkg.sv ***
package wdo_pkg;

    // bus geometry
    localparam int WB_ADR_W = 18;
    localparam int WB_DAT_W = 32;
    localparam int REG_IDX_W = 16;
    localparam int REG_IDX_LSB = 2;

    // register indices, byte address is four times the index
    localparam logic [REG_IDX_W-1:0] IDX_OPTION_TWO = 16'h001E;
    localparam logic [REG_IDX_W-1:0] IDX_OPTION_ONE = 16'h001F;
    localparam logic [REG_IDX_W-1:0] IDX_STATUS = 16'h0020;
    localparam logic [REG_IDX_W-1:0] IDX_WATCHDOG_SERVICE = 16'hFFFF;

    // option register two fields
    localparam int OPT2_SERIAL_BAUD_CLOCK_SOURCE = 0;
    localparam int OPT2_OSC_RUN_IN_STOP = 1;

    // option register one fields
    localparam int OPT1_WATCHDOG_DISABLE = 0;
    localparam int OPT1_STOP_ENABLE = 1;
    localparam int OPT1_SHORT_STOP_RECOVERY = 2;
    localparam int OPT1_UNDERVOLT_TRIP_MODE_SELECT = 3;
    localparam int OPT1_UNDERVOLT_POWER_DISABLE = 4;
    localparam int OPT1_UNDERVOLT_RESET_DISABLE = 5;
    localparam int OPT1_UNDERVOLT_RUN_IN_STOP = 6;
    localparam int OPT1_WATCHDOG_RATE_SELECT = 7;

    // status register fields
    localparam int STAT_WATCHDOG_FLAG = 0;
    localparam int STAT_STOP_MODE = 1;
    localparam int STAT_COUNT_LSB = 8;

    localparam logic [7:0] OPTION_RESET = 8'h00;

    // watchdog structure
    localparam int PRESCALE_W = 12;
    localparam int WD_COUNT_W = 6;
    localparam int PRESCALE_KEEP = 4; // stages 1..4 survive a service write
    localparam int WD_TICKS = 64;
    localparam int LONG_TIMEOUT_CYCLES = 262128;
    localparam int SHORT_TIMEOUT_CYCLES = 8176;

    // stop recovery and power-on timing, in crystal clock cycles
    localparam int SHORT_RECOVERY_CYCLES = 32;
    localparam int LONG_RECOVERY_CYCLES = 4096;
    localparam int POR_SETTLE_CYCLES = 4096;
    localparam int RESET_PULSE_CYCLES = 32;
    localparam int DELAY_W = 13;

    // pin synchroniser
    localparam int PIN_COUNT = 3;
    localparam int PIN_RESET_N = 0;
    localparam int PIN_TST_IRQ = 1;
    localparam int PIN_TST_RST = 2;
    localparam logic [PIN_COUNT-1:0] PIN_IDLE = 3'h1;

    typedef enum logic [1:0] {
        WDO_RUN,
        WDO_STOP,
        WDO_RECOVER
    } wdo_power_t;

endpackage : wdo_pkg

// *** hdl/wdo_top.sv ***
// Behaviour
// - each option register takes only its first write after any reset
// - reset clears option bits; trip-mode bit cleared only by power-on reset
// - trip-mode bit writable once per power-on reset only
// - oscillator-run-in-stop set keeps crystal running in stop, else stops
// - baud source bit picks bus clock when 1, oscillator when 0
// - rate select: 8176 cycles when 1, 262128 when 0; reset clears
// - undervolt inhibit runs in stop only with undervolt-run-in-stop set, power-disable clear
// - reset-disable blocks undervolt resets; power-disable switches inhibit off
// - trip-mode select: 5V mode when 1, 3V mode when 0
// - short recovery bit: 32 cycle stop exit, else 4096 cycles
// - stop exit through the reset pin always uses the long delay
// - stop-enable clear makes STOP an illegal-opcode reset instead of stop
// - watchdog disable bit 1 stops the watchdog, 0 lets it run
// - watchdog is a 6-bit counter behind a 12-bit prescaler; overflow resets
// - service location reads back the reset vector low byte
// - timeout drives reset pin low 32 cycles and sets watchdog flag
// - stop mode gates the watchdog clock and clears the prescaler
// - prescaler cleared once 4096 cycles after power-up
// - internal reset clears prescaler and counter; vector fetch clears prescaler
// - monitor and test-voltage conditions keep the watchdog disabled
// - the watchdog keeps counting in wait mode
`timescale 1ns/1ps
module wdo_top #(
    parameter int P_LONG_TIMEOUT = wdo_pkg::LONG_TIMEOUT_CYCLES,
    parameter int P_SHORT_TIMEOUT = wdo_pkg::SHORT_TIMEOUT_CYCLES
) (
    // clock and power-on reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [wdo_pkg::WB_ADR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [wdo_pkg::WB_DAT_W-1:0] i_wb_dat,
    output logic [wdo_pkg::WB_DAT_W-1:0] o_wb_dat,
    output logic o_wb_ack,
    // core events, same clock
    input wire logic i_int_reset,
    input wire logic i_vector_fetch,
    input wire logic i_stop_instr,
    input wire logic i_wakeup,
    input wire logic i_monitor_mode,
    input wire logic i_blank_vectors,
    input wire logic i_break_state,
    input wire logic [7:0] i_reset_vector_low,
    // pins from outside the clock domain
    input wire logic i_reset_pin_n,
    input wire logic i_tst_on_irq,
    input wire logic i_tst_on_rst,
    // option outputs
    output logic o_osc_enable,
    output logic o_serial_baud_clock_source,
    output logic o_undervolt_enable,
    output logic o_undervolt_reset_enable,
    output logic o_undervolt_trip_5v,
    // power mode and resets
    output logic o_stop_mode,
    output logic o_cpu_clock_enable,
    output logic o_illegal_opcode_reset,
    output logic o_reset_pin_low,
    output logic o_watchdog_flag
);
    import wdo_pkg::*;

    localparam logic [PRESCALE_W-1:0] LONG_TAP = PRESCALE_W'((P_LONG_TIMEOUT + 16) / WD_TICKS - 1);
    localparam logic [PRESCALE_W-1:0] SHORT_TAP = PRESCALE_W'((P_SHORT_TIMEOUT + 16) / WD_TICKS - 1);
    localparam logic [DELAY_W-1:0] SHORT_REC = DELAY_W'(SHORT_RECOVERY_CYCLES - 1);
    localparam logic [DELAY_W-1:0] LONG_REC = DELAY_W'(LONG_RECOVERY_CYCLES - 1);
    localparam logic [DELAY_W-1:0] POR_LAST = DELAY_W'(POR_SETTLE_CYCLES - 1);
    localparam logic [5:0] PULSE_LAST = 6'(RESET_PULSE_CYCLES - 1);
    localparam logic [PRESCALE_W-1:0] SERVICE_MASK = {{(PRESCALE_W-PRESCALE_KEEP){1'b0}}, {PRESCALE_KEEP{1'b1}}};

    function automatic logic wdo_hit(input logic [WB_ADR_W-1:0] adr, input logic [REG_IDX_W-1:0] idx);
        wdo_hit = (adr[WB_ADR_W-1:REG_IDX_LSB] == idx);
    endfunction : wdo_hit

    // pin synchronisers: three stages, change accepted when two and three agree
    logic [PIN_COUNT-1:0] pin_s1, pin_s2, pin_s3, pin_level;
    wire [PIN_COUNT-1:0] pin_raw = {i_tst_on_rst, i_tst_on_irq, i_reset_pin_n};
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_s1 <= PIN_IDLE;
            pin_s2 <= PIN_IDLE;
            pin_s3 <= PIN_IDLE;
            pin_level <= PIN_IDLE;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_level <= (pin_s2 & pin_s3) | (pin_level & (pin_s2 ^ pin_s3));
        end
    end
    wire reset_pin_low = !pin_level[PIN_RESET_N];
    wire tst_irq = pin_level[PIN_TST_IRQ];
    wire tst_rst = pin_level[PIN_TST_RST];

    // state
    logic [7:0] opt_one, opt_two;
    logic one_written, two_written, trip_written;
    logic [PRESCALE_W-1:0] prescale;
    logic [WD_COUNT_W-1:0] wd_count;
    logic [5:0] pulse_cnt;
    logic [DELAY_W-1:0] por_cnt, rec_cnt, rec_last;
    logic por_done, monitor_lock;
    wdo_power_t power;

    // bus decode
    wire bus_req = i_wb_cyc && i_wb_stb;
    wire bus_wr = bus_req && o_wb_ack && i_wb_we && i_wb_sel[0];
    wire bus_rd_now = bus_req && !o_wb_ack && !i_wb_we;
    wire hit_one = wdo_hit(i_wb_adr, IDX_OPTION_ONE);
    wire hit_two = wdo_hit(i_wb_adr, IDX_OPTION_TWO);
    wire hit_stat = wdo_hit(i_wb_adr, IDX_STATUS);
    wire hit_srv = wdo_hit(i_wb_adr, IDX_WATCHDOG_SERVICE);
    wire wr_one = bus_wr && hit_one;
    wire wr_two = bus_wr && hit_two;
    wire service = bus_wr && hit_srv;

    // option fields
    wire rate_fast = opt_one[OPT1_WATCHDOG_RATE_SELECT];
    wire wd_disable_bit = opt_one[OPT1_WATCHDOG_DISABLE];
    wire stop_enable = opt_one[OPT1_STOP_ENABLE];
    wire short_rec = opt_one[OPT1_SHORT_STOP_RECOVERY];
    wire uv_pwr_dis = opt_one[OPT1_UNDERVOLT_POWER_DISABLE];
    wire uv_stop_en = opt_one[OPT1_UNDERVOLT_RUN_IN_STOP];

    // watchdog enable, tick and overflow
    wire monitor_tst = i_monitor_mode && (tst_irq || tst_rst);
    wire break_tst = i_break_state && tst_rst;
    wire wd_enable = !wd_disable_bit && !monitor_lock && !monitor_tst && !break_tst;
    wire wd_clocked = (power == WDO_RUN) && por_done;
    wire [PRESCALE_W-1:0] tap = rate_fast ? SHORT_TAP : LONG_TAP;
    wire wd_tick = wd_clocked && wd_enable && ((prescale & tap) == tap);
    wire wd_fire = wd_tick && (wd_count == {WD_COUNT_W{1'b1}}) && !service;
    wire int_rst = i_int_reset || wd_fire;

    // stop handling
    wire stop_taken = (power == WDO_RUN) && i_stop_instr && stop_enable;
    wire stop_illegal = (power == WDO_RUN) && i_stop_instr && !stop_enable;
    wire stop_exit_pin = (power == WDO_STOP) && reset_pin_low;
    wire stop_exit_irq = (power == WDO_STOP) && i_wakeup && !reset_pin_low;
    wire [DELAY_W-1:0] next_rec_last = (stop_exit_irq && short_rec) ? SHORT_REC : LONG_REC;

    // option write acceptance, only the first write after a reset lands
    wire take_one = wr_one && !one_written;
    wire take_two = wr_two && !two_written;
    wire take_trip = wr_one && !trip_written;
    wire [7:0] trip_mask = 8'(1 << OPT1_UNDERVOLT_TRIP_MODE_SELECT);
    wire [7:0] next_opt_one = ((take_one ? i_wb_dat[7:0] : opt_one) & ~trip_mask)
                            | ((take_trip ? i_wb_dat[7:0] : opt_one) & trip_mask);

    // read mux, answers with zero for unmapped words
    wire [WB_DAT_W-1:0] stat_word = WB_DAT_W'({wd_count, 8'h00}) | WB_DAT_W'({power == WDO_STOP, o_watchdog_flag});
    wire [WB_DAT_W-1:0] next_rdata = hit_one ? WB_DAT_W'(opt_one)
                                   : hit_two ? WB_DAT_W'(opt_two)
                                   : hit_stat ? stat_word
                                   : hit_srv ? WB_DAT_W'(i_reset_vector_low)
                                   : {WB_DAT_W{1'b0}};

    // wishbone handshake: ack one cycle after the strobe, dropped the next cycle
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= {WB_DAT_W{1'b0}};
        end else begin
            o_wb_ack <= bus_req && !o_wb_ack;
            o_wb_dat <= bus_rd_now ? next_rdata : {WB_DAT_W{1'b0}};
        end
    end

    // option registers; the trip bit and its write-once flag survive internal resets
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            opt_one <= OPTION_RESET;
            opt_two <= OPTION_RESET;
            one_written <= 1'b0;
            two_written <= 1'b0;
            trip_written <= 1'b0;
        end else if (int_rst) begin
            opt_one <= opt_one & trip_mask;
            opt_two <= OPTION_RESET;
            one_written <= 1'b0;
            two_written <= 1'b0;
        end else begin
            opt_one <= next_opt_one;
            if (take_two) begin
                opt_two <= i_wb_dat[7:0];
            end
            one_written <= one_written || wr_one;
            two_written <= two_written || wr_two;
            trip_written <= trip_written || wr_one;
        end
    end

    // power-on settle counter, a single prescaler clear when it expires
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            por_cnt <= {DELAY_W{1'b0}};
            por_done <= 1'b0;
        end else if (!por_done) begin
            por_cnt <= por_cnt + DELAY_W'(1);
            por_done <= (por_cnt == POR_LAST);
        end
    end

    // blank-vector monitor entry latches the watchdog off until power-on reset
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            monitor_lock <= 1'b0;
        end else if (i_monitor_mode && i_blank_vectors && !tst_irq) begin
            monitor_lock <= 1'b1;
        end
    end

    // prescaler and counter; the prescaler runs even when disabled counting is held
    wire pre_clear = int_rst || i_vector_fetch || stop_taken || (power != WDO_RUN)
                   || (!por_done && por_cnt == POR_LAST);
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            prescale <= {PRESCALE_W{1'b0}};
        end else if (pre_clear) begin
            prescale <= {PRESCALE_W{1'b0}};
        end else if (service) begin
            prescale <= prescale & SERVICE_MASK;
        end else if (wd_clocked) begin
            prescale <= prescale + PRESCALE_W'(1);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wd_count <= {WD_COUNT_W{1'b0}};
        end else if (int_rst || service || !wd_enable) begin
            wd_count <= {WD_COUNT_W{1'b0}};
        end else if (wd_tick) begin
            wd_count <= wd_count + WD_COUNT_W'(1);
        end
    end

    // timeout reset pulse on the reset pin
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pulse_cnt <= 6'h00;
            o_reset_pin_low <= 1'b0;
        end else if (wd_fire) begin
            pulse_cnt <= 6'h00;
            o_reset_pin_low <= 1'b1;
        end else if (o_reset_pin_low) begin
            pulse_cnt <= pulse_cnt + 6'h01;
            o_reset_pin_low <= (pulse_cnt != PULSE_LAST);
        end
    end

    // watchdog cause flag, cleared by reading status; a new timeout wins
    wire stat_read = bus_req && o_wb_ack && !i_wb_we && hit_stat;
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_watchdog_flag <= 1'b0;
        end else begin
            o_watchdog_flag <= wd_fire || (o_watchdog_flag && !stat_read);
        end
    end

    // stop mode sequencer
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            power <= WDO_RUN;
            rec_cnt <= {DELAY_W{1'b0}};
            rec_last <= LONG_REC;
        end else if (int_rst) begin
            power <= WDO_RUN;
            rec_cnt <= {DELAY_W{1'b0}};
        end else begin
            unique case (power)
                WDO_RUN: begin
                    if (stop_taken) begin
                        power <= WDO_STOP;
                    end
                end
                WDO_STOP: begin
                    if (stop_exit_pin || stop_exit_irq) begin
                        power <= WDO_RECOVER;
                        rec_cnt <= {DELAY_W{1'b0}};
                        rec_last <= next_rec_last;
                    end
                end
                WDO_RECOVER: begin
                    rec_cnt <= rec_cnt + DELAY_W'(1);
                    if (rec_cnt == rec_last) begin
                        power <= WDO_RUN;
                    end
                end
            endcase
        end
    end

    // registered option and mode outputs
    wire next_stop = ((power == WDO_STOP) || stop_taken) && !int_rst;
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_osc_enable <= 1'b1;
            o_serial_baud_clock_source <= 1'b0;
            o_undervolt_enable <= 1'b1;
            o_undervolt_reset_enable <= 1'b1;
            o_undervolt_trip_5v <= 1'b0;
            o_stop_mode <= 1'b0;
            o_cpu_clock_enable <= 1'b1;
            o_illegal_opcode_reset <= 1'b0;
        end else begin
            o_osc_enable <= !next_stop || opt_two[OPT2_OSC_RUN_IN_STOP];
            o_serial_baud_clock_source <= opt_two[OPT2_SERIAL_BAUD_CLOCK_SOURCE];
            o_undervolt_enable <= !uv_pwr_dis && (!next_stop || uv_stop_en);
            o_undervolt_reset_enable <= !opt_one[OPT1_UNDERVOLT_RESET_DISABLE];
            o_undervolt_trip_5v <= opt_one[OPT1_UNDERVOLT_TRIP_MODE_SELECT];
            o_stop_mode <= next_stop;
            o_cpu_clock_enable <= !next_stop && (power != WDO_RECOVER || rec_cnt == rec_last);
            o_illegal_opcode_reset <= stop_illegal;
        end
    end

endmodule : wdo_top

// *** tb/wdo_top_asserts.sv ***
`timescale 1ns/1ps
module wdo_top_asserts
    import wdo_pkg::*;
#(
    parameter int P_LONG_TIMEOUT = 1008,
    parameter int P_SHORT_TIMEOUT = 496
) (
    // clock, reset and bus
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [wdo_pkg::WB_ADR_W-1:0] i_wb_adr,
    input wire logic [wdo_pkg::WB_DAT_W-1:0] o_wb_dat,
    input wire logic o_wb_ack,
    // core events and outputs
    input wire logic i_stop_instr,
    input wire logic [7:0] i_reset_vector_low,
    input wire logic o_osc_enable,
    input wire logic o_undervolt_trip_5v,
    input wire logic o_stop_mode,
    input wire logic o_cpu_clock_enable,
    input wire logic o_illegal_opcode_reset,
    input wire logic o_reset_pin_low,
    input wire logic o_watchdog_flag
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    // length of the reset pin pulse, zero while the pin is released
    logic [7:0] pin_cnt;
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_cnt <= 8'h00;
        end else begin
            pin_cnt <= o_reset_pin_low ? pin_cnt + 8'h01 : 8'h00;
        end
    end

    property p_ack_resp; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack; endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("bus request not answered next cycle");
    property p_ack_pulse; o_wb_ack |=> !o_wb_ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_svc_read;
        i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack && i_wb_adr == 18'h3FFFC
            |=> o_wb_dat == {24'h000000, $past(i_reset_vector_low)};
    endproperty
    a_svc_read: assert property (p_svc_read) else $error("service read not vector low byte");
    property p_stop_cause; $rose(o_stop_mode) |-> $past(i_stop_instr); endproperty
    a_stop_cause: assert property (p_stop_cause) else $error("stop entered without instruction");
    property p_ill_pulse; o_illegal_opcode_reset |-> $past(i_stop_instr) ##1 !o_illegal_opcode_reset; endproperty
    a_ill_pulse: assert property (p_ill_pulse) else $error("illegal opcode pulse wrong");
    property p_pin_len; $fell(o_reset_pin_low) |-> pin_cnt == 8'h20; endproperty
    a_pin_len: assert property (p_pin_len) else $error("reset pin pulse not 32 cycles");
    property p_flag; $rose(o_reset_pin_low) |-> ##[0:1] o_watchdog_flag; endproperty
    a_flag: assert property (p_flag) else $error("watchdog flag not set on timeout");
    property p_osc; !o_osc_enable |-> o_stop_mode; endproperty
    a_osc: assert property (p_osc) else $error("oscillator off outside stop");
    property p_cpu; o_stop_mode |-> !o_cpu_clock_enable; endproperty
    a_cpu: assert property (p_cpu) else $error("cpu clock running in stop");
    // trip bit may only move right after a bus write, never on internal reset
    property p_trip; $changed(o_undervolt_trip_5v) |-> $past(o_wb_ack) || $past(o_wb_ack, 2); endproperty
    a_trip: assert property (p_trip) else $error("trip mode changed without write");

    c_stop: cover property ($rose(o_stop_mode));
    c_pin: cover property ($fell(o_reset_pin_low));
    c_ill: cover property (o_illegal_opcode_reset);
endmodule : wdo_top_asserts

// *** tb/wdo_top_tb.sv ***
`timescale 1ns/1ps
module wdo_top_tb;
    import wdo_pkg::*;
    localparam int LT = 1008;
    localparam int ST = 496;
    localparam logic [17:0] A_OPT2 = 18'h00078;
    localparam logic [17:0] A_OPT1 = 18'h0007C;
    localparam logic [17:0] A_STAT = 18'h00080;
    localparam logic [17:0] A_SVC = 18'h3FFFC;
    // rows: option one, option two, {baud, undervolt reset on, trip 5v, undervolt on}
    localparam logic [19:0] ROWS [3] = '{20'h2901B, 20'h11026, 20'h0103F};
    logic i_ref_clk, i_rstn, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack;
    logic [17:0] i_wb_adr;
    logic [3:0] i_wb_sel;
    logic [31:0] i_wb_dat, o_wb_dat, q;
    logic i_int_reset, i_vector_fetch, i_stop_instr, i_wakeup, i_monitor_mode, i_blank_vectors;
    logic i_break_state, i_reset_pin_n, i_tst_on_irq, i_tst_on_rst, bad;
    logic [7:0] i_reset_vector_low;
    logic o_osc_enable, o_serial_baud_clock_source, o_undervolt_enable, o_undervolt_reset_enable;
    logic o_undervolt_trip_5v, o_stop_mode, o_cpu_clock_enable, o_illegal_opcode_reset;
    logic o_reset_pin_low, o_watchdog_flag;
    int err_count = 0, n_compared = 0, cyc_count = 0, n, lim;

    // shortened timeouts keep the run small
    wdo_top #(.P_LONG_TIMEOUT(LT), .P_SHORT_TIMEOUT(ST)) dut_u (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
        .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
        .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_int_reset(i_int_reset),
        .i_vector_fetch(i_vector_fetch), .i_stop_instr(i_stop_instr), .i_wakeup(i_wakeup),
        .i_monitor_mode(i_monitor_mode), .i_blank_vectors(i_blank_vectors), .i_break_state(i_break_state),
        .i_reset_vector_low(i_reset_vector_low), .i_reset_pin_n(i_reset_pin_n), .i_tst_on_irq(i_tst_on_irq),
        .i_tst_on_rst(i_tst_on_rst), .o_osc_enable(o_osc_enable),
        .o_serial_baud_clock_source(o_serial_baud_clock_source), .o_undervolt_enable(o_undervolt_enable),
        .o_undervolt_reset_enable(o_undervolt_reset_enable), .o_undervolt_trip_5v(o_undervolt_trip_5v),
        .o_stop_mode(o_stop_mode), .o_cpu_clock_enable(o_cpu_clock_enable),
        .o_illegal_opcode_reset(o_illegal_opcode_reset), .o_reset_pin_low(o_reset_pin_low),
        .o_watchdog_flag(o_watchdog_flag));

    initial begin
        i_ref_clk = 1'b0;
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one classic cycle; ack and data are taken at the edge that samples ack high
    task automatic bus(input logic we, input logic [17:0] a, input logic [7:0] d, output logic [31:0] r);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= we;
        i_wb_adr <= a;
        i_wb_dat <= {24'h000000, d};
        do @(posedge i_ref_clk); while (o_wb_ack !== 1'b1);
        r = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        i_wb_we <= 1'b0;
        @(posedge i_ref_clk);
    endtask : bus

    task automatic fresh();
        i_int_reset <= 1'b1;
        @(posedge i_ref_clk);
        i_int_reset <= 1'b0;
        @(posedge i_ref_clk);
    endtask : fresh

    // watch that no watchdog reset comes out for c cycles
    task automatic quiet(input int c, output logic b);
        b = 1'b0;
        repeat (c) begin
            @(posedge i_ref_clk);
            b = b | (o_reset_pin_low !== 1'b0);
        end
    endtask : quiet

    task end_of_test;
        if (err_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    // hang guard, well above the expected run length
    always @(posedge i_ref_clk) begin
        cyc_count++;
        if (cyc_count == 40000) begin
            err_count++;
            end_of_test();
        end
    end

    initial begin
        {i_rstn, i_wb_cyc, i_wb_stb, i_wb_we, i_int_reset, i_vector_fetch, i_stop_instr, i_wakeup} = 8'h00;
        {i_monitor_mode, i_blank_vectors, i_break_state, i_tst_on_irq, i_tst_on_rst} = 5'h00;
        i_wb_adr = 18'h00000;
        i_wb_sel = 4'h1;
        i_wb_dat = 32'h00000000;
        i_reset_vector_low = 8'hA5;
        i_reset_pin_n = 1'b1;
        repeat (10) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        @(posedge i_ref_clk);
        check({21'h0, o_wb_ack, o_osc_enable, o_serial_baud_clock_source, o_undervolt_enable,
            o_undervolt_reset_enable, o_undervolt_trip_5v, o_stop_mode, o_cpu_clock_enable,
            o_illegal_opcode_reset, o_reset_pin_low, o_watchdog_flag}, 32'h000002C8);
        bus(1'b0, A_OPT1, 8'h00, q); check(q, 32'h00000000);
        bus(1'b0, 18'h00084, 8'h00, q); check(q, 32'h00000000);
        bus(1'b0, A_SVC, 8'h00, q); check(q, 32'h000000A5);
        // row 0 runs straight after power-on, so its trip bit sticks for later rows
        for (int r = 0; r < 3; r++) begin
            if (r > 0) fresh();
            bus(1'b1, A_OPT2, ROWS[r][11:4], q);
            bus(1'b1, A_OPT1, ROWS[r][19:12], q);
            bus(1'b1, A_OPT1, ~ROWS[r][19:12], q);
            bus(1'b1, A_OPT2, ~ROWS[r][11:4], q);
            bus(1'b0, A_OPT1, 8'h00, q); check(q, {24'h0, ROWS[r][19:12] | 8'h08});
            bus(1'b0, A_OPT2, 8'h00, q); check(q, {24'h0, ROWS[r][11:4]});
            check({28'h0, o_serial_baud_clock_source, o_undervolt_reset_enable, o_undervolt_trip_5v,
                o_undervolt_enable}, {28'h0, ROWS[r][3:0]});
        end
        // disable bit keeps the watchdog quiet across and past the power-on settle time
        fresh();
        bus(1'b1, A_OPT1, 8'h01, q);
        quiet(5400, bad); check({31'h0, bad}, 32'h0);
        // short then long rate; a mid-way service restarts the period
        for (int k = 0; k < 2; k++) begin
            fresh();
            bus(1'b1, A_OPT1, k == 0 ? 8'h80 : 8'h00, q);
            bus(1'b1, A_SVC, 8'h5A, q);
            repeat (300) @(posedge i_ref_clk);
            bus(1'b1, A_SVC, 8'h00, q);
            n = 0;
            lim = k == 0 ? ST : LT;
            while (o_reset_pin_low !== 1'b1 && n < 3000) begin
                @(posedge i_ref_clk);
                n++;
            end
            check({31'h0, n >= lim - 2 && n <= lim + 20}, 32'h1);
            repeat (40) @(posedge i_ref_clk);
            bus(1'b0, A_STAT, 8'h00, q); check({31'h0, q[0]}, 32'h1);
            bus(1'b0, A_STAT, 8'h00, q); check({31'h0, q[0]}, 32'h0);
            bus(1'b0, A_OPT1, 8'h00, q); check(q, 32'h00000008);
        end
        // stop with short wake by interrupt, then long wake by the reset pin
        for (int k = 0; k < 2; k++) begin
            fresh();
            bus(1'b1, A_OPT2, k == 0 ? 8'h00 : 8'h02, q);
            bus(1'b1, A_OPT1, k == 0 ? 8'h07 : 8'h03, q);
            i_stop_instr <= 1'b1;
            @(posedge i_ref_clk);
            i_stop_instr <= 1'b0;
            repeat (2) @(posedge i_ref_clk);
            check({29'h0, o_stop_mode, o_osc_enable, o_cpu_clock_enable}, k == 0 ? 32'h4 : 32'h6);
            if (k == 0) i_wakeup <= 1'b1;
            else i_reset_pin_n <= 1'b0;
            n = 0;
            lim = k == 0 ? 32 : 4096;
            while (o_cpu_clock_enable !== 1'b1 && n < 5000) begin
                @(posedge i_ref_clk);
                n++;
                i_wakeup <= 1'b0;
                if (n == 8) i_reset_pin_n <= 1'b1;
            end
            check({31'h0, n >= lim - 2 && n <= lim + 12}, 32'h1);
        end
        // stop while the instruction is disabled
        fresh();
        bus(1'b1, A_OPT1, 8'h01, q);
        i_stop_instr <= 1'b1;
        @(posedge i_ref_clk);
        i_stop_instr <= 1'b0;
        bad = 1'b0;
        repeat (3) begin
            @(posedge i_ref_clk);
            bad = bad | (o_illegal_opcode_reset === 1'b1);
        end
        check({30'h0, bad, o_stop_mode}, 32'h2);
        // break with test voltage on reset pin
        i_break_state <= 1'b1;
        i_tst_on_rst <= 1'b1;
        fresh();
        bus(1'b1, A_OPT1, 8'h80, q);
        quiet(700, bad); check({31'h0, bad}, 32'h0);
        i_tst_on_rst <= 1'b0;
        // monitor entry through blank vectors keeps the watchdog quiet
        fresh();
        i_monitor_mode <= 1'b1;
        i_blank_vectors <= 1'b1;
        @(posedge i_ref_clk);
        bus(1'b1, A_OPT1, 8'h80, q);
        bus(1'b1, A_SVC, 8'h00, q);
        quiet(700, bad); check({31'h0, bad}, 32'h0);
        end_of_test();
    end
endmodule : wdo_top_tb

bind wdo_top wdo_top_asserts #(.P_LONG_TIMEOUT(P_LONG_TIMEOUT), .P_SHORT_TIMEOUT(P_SHORT_TIMEOUT)) u_chk (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_stop_instr(i_stop_instr),
    .i_reset_vector_low(i_reset_vector_low), .o_osc_enable(o_osc_enable),
    .o_undervolt_trip_5v(o_undervolt_trip_5v), .o_stop_mode(o_stop_mode),
    .o_cpu_clock_enable(o_cpu_clock_enable), .o_illegal_opcode_reset(o_illegal_opcode_reset),
    .o_reset_pin_low(o_reset_pin_low), .o_watchdog_flag(o_watchdog_flag));
